// >>> inc/nor_pkg.sv
`default_nettype none
package nor_pkg;
   // register byte offsets on the apb bus
   localparam logic [11:0] NOR_OFF_CTRL   = 12'h000;
   localparam logic [11:0] NOR_OFF_TOP_LO = 12'h004;
   localparam logic [11:0] NOR_OFF_TOP_HI = 12'h008;
   localparam logic [11:0] NOR_OFF_STATUS = 12'h00c;
   localparam logic [11:0] NOR_OFF_EVENT  = 12'h010;
   localparam logic [11:0] NOR_OFF_EVCLR  = 12'h014;
   localparam logic [11:0] NOR_OFF_MASK   = 12'h018;
   // control bit positions and reset values
   localparam int          NOR_CTRL_PHYS   = 0;
   localparam int          NOR_CTRL_POSTED = 1;
   localparam int          NOR_CTRL_TOP    = 2;
   localparam logic [2:0]  NOR_CTRL_RST    = 3'h0;
   localparam logic [47:0] NOR_TOP_RST     = 48'h0000_ffff_ffff;
   // node offset map
   localparam logic [47:0] NOR_LOW_TOP_DEF = 48'h0000_ffff_ffff;
   localparam logic [47:0] NOR_UPPER_BASE  = 48'hffff_0000_0000;
   localparam logic [47:0] NOR_CSR_BASE    = 48'hffff_f000_0000;
   localparam logic [47:0] NOR_CSR_HW_LO   = 48'hffff_f000_0400;
   localparam logic [47:0] NOR_CSR_HW_HI   = 48'hffff_f000_07ff;
   // event bit positions
   localparam int          NOR_EV_W        = 8;
   localparam int          NOR_EV_DMA_DONE = 0;
   localparam int          NOR_EV_DMA_ABRT = 1;
   localparam int          NOR_EV_SELFID   = 2;
   localparam int          NOR_EV_PHYS_WR  = 3;
   localparam int          NOR_EV_BUSY     = 4;
   localparam int          NOR_EV_CSR_HW   = 5;
   localparam logic [NOR_EV_W-1:0] NOR_EV_RST = 8'h00;
   // quadlet geometry and buffer depth
   localparam logic [2:0]  NOR_QUAD_BYTES  = 3'h4;
   localparam logic [1:0]  NOR_BUF_DEPTH   = 2'h2;

   typedef enum logic [3:0] {
      NOR_ACK_COMPLETE = 4'h1,
      NOR_ACK_PENDING  = 4'h2,
      NOR_ACK_BUSY     = 4'h4,
      NOR_ACK_DATA_ERR = 4'hd
   } nor_ack_type;

   typedef enum logic [1:0] {
      NOR_IDLE  = 2'b00,
      NOR_WRITE = 2'b01,
      NOR_FLUSH = 2'b10
   } nor_state_type;

   typedef struct packed {
      logic [47:0] offset;
      logic        is_write;
      logic [15:0] len;
      logic        hdr_ok;
      logic        data_ok;
   } nor_req_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
   } nor_hmw_type;

   typedef struct packed {
      logic [31:0] data;
      logic [2:0]  nbytes;
   } nor_tx_type;
endpackage
`default_nettype wire

// >>> rtl/nor_router.sv
`timescale 1ns/10ps
`default_nettype none
module nor_router (
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output var  logic [31:0]        prdata,
   output var  logic               pready,
   output var  logic               pslverr,
   input  wire logic               rq_valid,
   input  wire nor_pkg::nor_req_type rq,
   output var  logic               ack_valid,
   output var  nor_pkg::nor_ack_type ack_code,
   output var  logic               sw_valid,
   input  wire logic               sw_ready,
   output var  nor_pkg::nor_req_type sw_req,
   output var  logic               csr_hw_valid,
   output var  nor_pkg::nor_req_type csr_hw_req,
   output var  logic               phys_rd_valid,
   input  wire logic               phys_rd_ready,
   output var  logic [31:0]        phys_rd_addr,
   input  wire logic               rx_q_valid,
   output var  logic               rx_q_ready,
   input  wire logic [31:0]        rx_q_data,
   output var  logic               hm_valid,
   input  wire logic               hm_ready,
   output var  nor_pkg::nor_hmw_type hm_word,
   input  wire logic               tx_in_valid,
   output var  logic               tx_in_ready,
   input  wire nor_pkg::nor_tx_type tx_in,
   output var  logic               tx_out_valid,
   input  wire logic               tx_out_ready,
   output var  logic [31:0]        tx_out_data,
   input  wire logic               dma_done,
   input  wire logic               dma_abort,
   input  wire logic               dma_wb_en,
   input  wire logic               dma_irq_en,
   input  wire logic [31:0]        dma_status,
   input  wire logic               selfid_rx,
   output var  logic               status_wb_valid,
   output var  logic [31:0]        status_wb_data,
   output var  logic               host_irq
);
   logic [2:0]                     ctrl;
   logic [47:0]                    low_range_top;
   logic [nor_pkg::NOR_EV_W-1:0]   pending_event_reg;
   logic [nor_pkg::NOR_EV_W-1:0]   event_enable_mask;
   logic [nor_pkg::NOR_EV_W-1:0]   ev_set;
   logic [nor_pkg::NOR_EV_W-1:0]   ev_clr;
   logic                           apb_wr;
   logic                           mapped;
   logic [31:0]                    rd_mux;
   logic [47:0]                    top;
   logic                           in_low;
   logic                           in_mid;
   logic                           in_upper;
   logic                           in_csr;
   logic                           csr_hw;
   logic                           to_phys;
   logic                           to_sw;
   logic                           room;
   logic                           take;
   nor_pkg::nor_ack_type           code;
   nor_pkg::nor_state_type         state;
   logic [31:0]                    addr_w;
   logic [2:0]                     lane_start;
   logic [1:0]                     sh;
   logic [15:0]                    rem;
   logic [14:0]                    qleft;
   logic [31:0]                    carry;
   logic [63:0]                    shifted;
   logic [16:0]                    lane_end;
   logic [3:0]                     be;
   logic [2:0]                     avail;
   logic [15:0]                    next_rem;
   logic                           hm_free;
   logic                           rx_fire;
   logic                           phys_done;
   nor_pkg::nor_req_type           buf_mem [2];
   logic                           wp;
   logic                           rp;
   logic [1:0]                     cnt;
   logic                           buf_ready;
   logic                           push;
   logic                           pop;
   logic [31:0]                    tx_mask;

   // apb decode, zero wait states
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite && mapped;
   // only whole-word registers exist, unknown offsets error
   // whole word access
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0;
      case (paddr)
         nor_pkg::NOR_OFF_CTRL:   rd_mux = {29'h0, ctrl};
         nor_pkg::NOR_OFF_TOP_LO: rd_mux = low_range_top[31:0];
         nor_pkg::NOR_OFF_TOP_HI: rd_mux = {16'h0, low_range_top[47:32]};
         nor_pkg::NOR_OFF_STATUS: rd_mux = {26'h0, cnt, phys_rd_valid,
                                            hm_valid, state};
         nor_pkg::NOR_OFF_EVENT:  rd_mux = {24'h0, pending_event_reg};
         nor_pkg::NOR_OFF_EVCLR:  rd_mux = {24'h0, pending_event_reg};
         nor_pkg::NOR_OFF_MASK:   rd_mux = {24'h0, event_enable_mask};
         default:                 mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // read data captured in the setup cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // control, top bound and mask registers
   // programmable low top
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl              <= nor_pkg::NOR_CTRL_RST;
         low_range_top     <= nor_pkg::NOR_TOP_RST;
         event_enable_mask <= nor_pkg::NOR_EV_RST;
      end else if (apb_wr) begin
         case (paddr)
            nor_pkg::NOR_OFF_CTRL:   ctrl <= pwdata[2:0];
            nor_pkg::NOR_OFF_TOP_LO: low_range_top[31:0] <= pwdata;
            nor_pkg::NOR_OFF_TOP_HI: low_range_top[47:32] <= pwdata[15:0];
            nor_pkg::NOR_OFF_MASK:
               event_enable_mask <= pwdata[nor_pkg::NOR_EV_W-1:0];
            default: ;
         endcase
      end
   end

   // offset classification
   // low range test
   assign top = ctrl[nor_pkg::NOR_CTRL_TOP] ? low_range_top
                                             : nor_pkg::NOR_LOW_TOP_DEF;
   assign in_low   = rq.offset <= top;
   assign in_mid   = !in_low && rq.offset < nor_pkg::NOR_UPPER_BASE;
   assign in_upper = !in_low && !in_mid && rq.offset < nor_pkg::NOR_CSR_BASE;
   assign in_csr   = !in_low && rq.offset >= nor_pkg::NOR_CSR_BASE;
   assign csr_hw   = in_csr && rq.offset >= nor_pkg::NOR_CSR_HW_LO
                     && rq.offset <= nor_pkg::NOR_CSR_HW_HI;
   assign to_phys  = in_low && ctrl[nor_pkg::NOR_CTRL_PHYS];
   assign to_sw    = !to_phys && !csr_hw;

   // room check and acknowledge choice
   // busy when no room
   always_comb begin
      if (to_phys) begin
         room = rq.is_write ? (state == nor_pkg::NOR_IDLE) : !phys_rd_valid;
      end else if (to_sw) begin
         room = buf_ready;
      end else begin
         room = 1'b1;
      end
      if (!rq.data_ok) begin
         code = nor_pkg::NOR_ACK_DATA_ERR;
      end else if (!room) begin
         code = nor_pkg::NOR_ACK_BUSY;
      end else if (!rq.is_write) begin
         code = nor_pkg::NOR_ACK_PENDING;
      end else if (to_phys) begin
         code = ctrl[nor_pkg::NOR_CTRL_POSTED] ? nor_pkg::NOR_ACK_COMPLETE
                                                : nor_pkg::NOR_ACK_PENDING;
      end else if (in_low || in_mid) begin
         code = nor_pkg::NOR_ACK_COMPLETE;
      end else begin
         code = nor_pkg::NOR_ACK_PENDING;
      end
   end
   assign take = rq_valid && rq.hdr_ok && rq.data_ok && room;

   // acknowledge one cycle after the request
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_valid <= 1'b0;
         ack_code  <= nor_pkg::NOR_ACK_COMPLETE;
      end else begin
         ack_valid <= rq_valid && rq.hdr_ok;
         ack_code  <= code;
      end
   end

   // two-entry buffer toward the software path
   assign buf_ready = cnt < nor_pkg::NOR_BUF_DEPTH;
   assign push      = take && to_sw;
   assign pop       = sw_valid && sw_ready;
   assign sw_valid  = cnt != 2'h0;
   assign sw_req    = buf_mem[rp];
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wp  <= 1'b0;
         rp  <= 1'b0;
         cnt <= 2'h0;
      end else begin
         if (push) begin
            wp <= !wp;
         end
         if (pop) begin
            rp <= !rp;
         end
         cnt <= cnt + {1'b0, push} - {1'b0, pop};
      end
   end
   // buffer storage
   always_ff @(posedge mclk) begin
      if (push) begin
         buf_mem[wp] <= rq;
      end
   end

   // locally answered csr requests
   // hardware answers subset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         csr_hw_valid <= 1'b0;
         csr_hw_req   <= '0;
      end else begin
         csr_hw_valid <= take && csr_hw;
         csr_hw_req   <= rq;
      end
   end

   // physical read request toward host memory
   // bridge reads
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phys_rd_valid <= 1'b0;
         phys_rd_addr  <= 32'h0;
      end else if (take && to_phys && !rq.is_write) begin
         phys_rd_valid <= 1'b1;
         phys_rd_addr  <= rq.offset[31:0];
      end else if (phys_rd_ready) begin
         phys_rd_valid <= 1'b0;
      end
   end

   // write aligner datapath
   assign hm_free    = !hm_valid || hm_ready;
   assign rx_q_ready = (state == nor_pkg::NOR_WRITE) && hm_free;
   assign rx_fire    = rx_q_valid && rx_q_ready;
   assign shifted    = {32'h0, rx_q_data} << {sh, 3'b000};
   assign lane_end   = {1'b0, rem} + {14'h0, lane_start};
   assign avail      = nor_pkg::NOR_QUAD_BYTES - lane_start;
   assign next_rem   = (rem > {13'h0, avail}) ? rem - {13'h0, avail} : 16'h0;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_be
         assign be[gi] = (3'(gi) >= lane_start) && (lane_end > 17'(gi));
      end
   endgenerate

   // realignment engine state
   // merge quadlets
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state      <= nor_pkg::NOR_IDLE;
         addr_w     <= 32'h0;
         sh         <= 2'h0;
         lane_start <= 3'h0;
         rem        <= 16'h0;
         qleft      <= 15'h0;
         carry      <= 32'h0;
      end else begin
         case (state)
            nor_pkg::NOR_IDLE: begin
               if (take && to_phys && rq.is_write && rq.len != 16'h0) begin
                  state      <= nor_pkg::NOR_WRITE;
                  addr_w     <= {rq.offset[31:2], 2'b00};
                  lane_start <= {1'b0, rq.offset[1:0]};
                  sh         <= rq.offset[1:0]; // lane shift kept per burst
                  rem        <= rq.len;
                  qleft      <= 15'(({1'b0, rq.len} + 17'h3) >> 2);
                  carry      <= 32'h0;
               end
            end
            nor_pkg::NOR_WRITE: begin
               if (rx_fire) begin
                  carry      <= shifted[63:32];
                  addr_w     <= addr_w + 32'h4;
                  lane_start <= 3'h0;
                  rem        <= next_rem;
                  qleft      <= qleft - 15'h1;
                  if (next_rem == 16'h0) begin
                     state <= nor_pkg::NOR_IDLE;
                  end else if (qleft == 15'h1) begin
                     state <= nor_pkg::NOR_FLUSH;
                  end
               end
            end
            nor_pkg::NOR_FLUSH: begin
               if (hm_free) begin
                  rem   <= 16'h0;
                  state <= nor_pkg::NOR_IDLE;
               end
            end
            default: state <= nor_pkg::NOR_IDLE;
         endcase
      end
   end
   assign phys_done = (rx_fire && next_rem == 16'h0)
                      || (state == nor_pkg::NOR_FLUSH && hm_free);

   // host memory write master
   // bridge writes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hm_valid <= 1'b0;
         hm_word  <= '0;
      end else if (rx_fire) begin
         hm_valid <= 1'b1;
         hm_word  <= '{addr: addr_w, be: be, data: shifted[31:0] | carry};
      end else if (state == nor_pkg::NOR_FLUSH && hm_free) begin
         hm_valid <= 1'b1;
         hm_word  <= '{addr: addr_w, be: be, data: carry};
      end else if (hm_ready) begin
         hm_valid <= 1'b0;
      end
   end

   // transmit zero padding
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pad
         assign tx_mask[gi*8 +: 8] = (3'(gi) < tx_in.nbytes) ? 8'hff : 8'h00;
      end
   endgenerate
   assign tx_in_ready = !tx_out_valid || tx_out_ready;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tx_out_valid <= 1'b0;
         tx_out_data  <= 32'h0;
      end else if (tx_in_ready) begin
         tx_out_valid <= tx_in_valid;
         tx_out_data  <= tx_in.data & tx_mask;
      end
   end

   // descriptor status write back
   // conditional status write
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         status_wb_valid <= 1'b0;
         status_wb_data  <= 32'h0;
      end else begin
         status_wb_valid <= dma_done && dma_wb_en;
         status_wb_data  <= dma_status;
      end
   end

   // event sources
   // dma, selfid, physical write, busy and local csr events
   always_comb begin
      ev_set = '0;
      ev_set[nor_pkg::NOR_EV_DMA_DONE] = dma_done && dma_irq_en;
      ev_set[nor_pkg::NOR_EV_DMA_ABRT] = dma_abort;
      ev_set[nor_pkg::NOR_EV_SELFID]   = selfid_rx;
      ev_set[nor_pkg::NOR_EV_PHYS_WR]  = phys_done;
      ev_set[nor_pkg::NOR_EV_BUSY]     = rq_valid && rq.hdr_ok
                                         && code == nor_pkg::NOR_ACK_BUSY;
      ev_set[nor_pkg::NOR_EV_CSR_HW]   = take && csr_hw;
   end
   assign ev_clr = (apb_wr && paddr == nor_pkg::NOR_OFF_EVCLR)
                   ? pwdata[nor_pkg::NOR_EV_W-1:0] : '0;

   // pending events, a new event beats a clear
   // clear by address
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pending_event_reg <= nor_pkg::NOR_EV_RST;
      end else begin
         pending_event_reg <= (pending_event_reg & ~ev_clr) | ev_set;
      end
   end
   assign host_irq = |(pending_event_reg & event_enable_mask);

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_good_req;
      rq_valid && rq.hdr_ok && rq.data_ok;
   endsequence
   sequence s_phys_wr_take;
      s_good_req and (to_phys && rq.is_write && room && rq.len != 16'h0);
   endsequence

   a_mid_write_ack: assert property (
      s_good_req and (in_mid && rq.is_write && buf_ready)
      |=> ack_valid && ack_code == nor_pkg::NOR_ACK_COMPLETE)
      else $error("middle write not acked complete");
   a_upper_write_ack: assert property (
      s_good_req and (in_upper && rq.is_write && buf_ready)
      |=> ack_valid && ack_code == nor_pkg::NOR_ACK_PENDING && sw_valid)
      else $error("upper write not pending to software");
   a_busy_no_room: assert property (
      s_good_req and (to_sw && !buf_ready && !sw_ready)
      |=> ack_code == nor_pkg::NOR_ACK_BUSY && cnt == 2'h2)
      else $error("full buffer without busy ack");
   a_mid_not_phys: assert property (
      s_good_req and (in_mid && !phys_rd_valid && state == nor_pkg::NOR_IDLE)
      |=> !phys_rd_valid && state == nor_pkg::NOR_IDLE)
      else $error("middle request reached physical path");
   a_low_to_soft: assert property (
      s_good_req and (in_low && !ctrl[nor_pkg::NOR_CTRL_PHYS] && cnt == 2'h0)
      |=> sw_valid)
      else $error("low request dropped");
   a_posted_engine: assert property (
      s_phys_wr_take and ctrl[nor_pkg::NOR_CTRL_POSTED]
      |=> ack_code == nor_pkg::NOR_ACK_COMPLETE
          && state != nor_pkg::NOR_IDLE)
      else $error("posted write not started");
   a_flush_step: assert property (
      state == nor_pkg::NOR_FLUSH && hm_free
      |=> state == nor_pkg::NOR_IDLE && hm_valid && hm_word.data == $past(carry))
      else $error("flush word lost");
   a_irq_event: assert property (
      |(ev_set & event_enable_mask) |=> host_irq)
      else $error("enabled event did not raise irq");
   a_set_over_clear: assert property (
      |ev_set
      |=> (pending_event_reg & $past(ev_set)) == $past(ev_set))
      else $error("clear beat a new event");
   a_clear_event: assert property (
      ev_clr[nor_pkg::NOR_EV_DMA_ABRT] && !ev_set[nor_pkg::NOR_EV_DMA_ABRT]
      |=> !pending_event_reg[nor_pkg::NOR_EV_DMA_ABRT])
      else $error("event clear ignored");
   a_pad_zero: assert property (
      tx_in_valid && tx_in_ready && tx_in.nbytes == 3'h3
      |=> tx_out_valid && tx_out_data[31:24] == 8'h0)
      else $error("pad bytes not zero");
   a_status_wb: assert property (
      dma_done && dma_wb_en
      |=> status_wb_valid && status_wb_data == $past(dma_status))
      else $error("status write back missing");
endmodule
`default_nettype wire

// >>> testbench/nor_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module nor_far_model (
   input  wire logic                 mclk,
   input  wire logic                 slow,
   input  wire logic                 hm_valid,
   output var  logic                 hm_ready,
   input  wire nor_pkg::nor_hmw_type hm_word,
   input  wire logic                 phys_rd_valid,
   output var  logic                 phys_rd_ready,
   input  wire logic                 tx_out_valid,
   output var  logic                 tx_out_ready,
   input  wire logic [31:0]          tx_out_data
);
   nor_pkg::nor_hmw_type mem_log [$];
   logic [31:0]          tx_log [$];
   logic                 tick = 1'h0;
   // slow mode accepts memory and link words every other cycle only; physical reads go every other cycle in both modes
   always @(posedge mclk) tick <= ~tick;
   assign hm_ready      = ~slow | tick;
   assign phys_rd_ready = tick;
   assign tx_out_ready  = ~slow | tick;
   // memory and link log each word
   always @(posedge mclk) begin
      if (hm_valid && hm_ready) mem_log.push_back(hm_word);
      if (tx_out_valid && tx_out_ready) tx_log.push_back(tx_out_data);
   end
endmodule
`default_nettype wire

// >>> testbench/nor_router_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nor_router_tb;
   logic        mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, rq_valid = 1'h0, sw_ready = 1'h0, slow = 1'h0;
   logic        rx_q_valid = 1'h0, tx_in_valid = 1'h0, dma_done = 1'h0;
   logic        dma_abort = 1'h0, dma_wb_en = 1'h1, dma_irq_en = 1'h1;
   logic        selfid_rx = 1'h0, err;
   logic [47:0] csr_seen = 48'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rx_q_data = 32'h0, q, wb_seen = 32'h0;
   logic [31:0] dma_status = 32'h1234_5678, rd_seen = 32'h0;
   logic        pready, pslverr, ack_valid, sw_valid, csr_hw_valid, host_irq;
   logic        phys_rd_valid, phys_rd_ready, rx_q_ready, hm_valid, hm_ready;
   logic        tx_in_ready, tx_out_valid, tx_out_ready, status_wb_valid;
   logic [31:0] prdata, phys_rd_addr, tx_out_data, status_wb_data;
   nor_pkg::nor_req_type rq = '0, sw_req, csr_hw_req;
   nor_pkg::nor_tx_type  tx_in = '0;
   nor_pkg::nor_ack_type ack_code;
   nor_pkg::nor_hmw_type hm_word;
   logic [47:0] sw_log [$];
   int          fails = 0, tests_run = 0;
   always #4 mclk = ~mclk;
   nor_router dut (.mclk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .rq_valid, .rq, .ack_valid, .ack_code,
      .sw_valid, .sw_ready, .sw_req, .csr_hw_valid, .csr_hw_req,
      .phys_rd_valid, .phys_rd_ready, .phys_rd_addr, .rx_q_valid, .rx_q_ready,
      .rx_q_data, .hm_valid, .hm_ready, .hm_word, .tx_in_valid, .tx_in_ready,
      .tx_in, .tx_out_valid, .tx_out_ready, .tx_out_data, .dma_done,
      .dma_abort, .dma_wb_en, .dma_irq_en, .dma_status, .selfid_rx,
      .status_wb_valid, .status_wb_data, .host_irq);
   nor_far_model far (.mclk, .slow, .hm_valid, .hm_ready, .hm_word,
      .phys_rd_valid, .phys_rd_ready, .tx_out_valid, .tx_out_ready,
      .tx_out_data);
   // record what leaves the software, local, status and physical read paths
   always @(posedge mclk) begin
      if (sw_valid && sw_ready) sw_log.push_back(sw_req.offset);
      if (csr_hw_valid) csr_seen <= csr_hw_req.offset;
      if (status_wb_valid) wb_seen <= status_wb_data;
      if (phys_rd_valid && phys_rd_ready) rd_seen <= phys_rd_addr;
   end
   task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
      tests_run++;
      if (exp !== got) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (pready !== 1'h1);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdc(logic [11:0] a, logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk("register", exp, q);
   endtask
   // one request, acknowledge looked at in the cycle after it
   task automatic req(logic [47:0] o, logic w, logic [15:0] n, logic h,
                      logic d, logic [3:0] exp);
      @(posedge mclk);
      rq_valid <= 1'h1;
      rq <= '{o, w, n, h, d};
      @(posedge mclk);
      rq_valid <= 1'h0;
      @(negedge mclk);
      chk("ack_valid", h, ack_valid);
      if (h) chk("ack_code", exp, ack_code);
      @(posedge mclk);
   endtask
   task automatic rxq(logic [31:0] d);
      @(posedge mclk);
      rx_q_valid <= 1'h1;
      rx_q_data <= d;
      do @(posedge mclk); while (rx_q_ready !== 1'h1);
      rx_q_valid <= 1'h0;
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'h0;
      rdc(nor_pkg::NOR_OFF_CTRL, 32'h0);
      rdc(nor_pkg::NOR_OFF_TOP_LO, 32'hffff_ffff);
      rdc(nor_pkg::NOR_OFF_TOP_HI, 32'h0);
      rdc(nor_pkg::NOR_OFF_MASK, 32'h0);
      apb(1'h0, 12'h020, 32'h0);
      chk("pslverr", 1, err);
      req(48'h0001_0000_0000, 1, 4, 1, 1, 4'h1);
      req(48'hffff_0000_0000, 1, 4, 1, 1, 4'h2);
      req(48'hffff_efff_fffc, 1, 4, 1, 1, 4'h4);
      sw_ready <= 1'h1;
      req(48'hffff_f000_1000, 1, 4, 1, 1, 4'h2);
      req(48'hffff_f000_0400, 0, 4, 1, 1, 4'h2);
      req(48'h0000_0000_0100, 1, 4, 1, 1, 4'h1);
      req(48'h0000_0000_0200, 0, 4, 1, 1, 4'h2);
      req(48'h0001_0000_0000, 1, 4, 1, 0, 4'hd);
      req(48'h0001_0000_0000, 1, 4, 0, 1, 4'h0);
      repeat (4) @(posedge mclk);
      chk("sw count", 5, sw_log.size());
      chk("sw first", 48'h0001_0000_0000, sw_log[0]);
      chk("sw second", 48'hffff_0000_0000, sw_log[1]);
      chk("csr local", 48'hffff_f000_0400, csr_seen);
      rdc(nor_pkg::NOR_OFF_EVENT, 32'h30);
      apb(1'h1, nor_pkg::NOR_OFF_EVCLR, 32'hff);
      rdc(nor_pkg::NOR_OFF_EVENT, 32'h0);
      apb(1'h1, nor_pkg::NOR_OFF_MASK, 32'h1);
      dma_done <= 1'h1;
      @(posedge mclk);
      dma_done <= 1'h0;
      repeat (3) @(posedge mclk);
      #1 chk("host_irq", 1, host_irq);
      chk("status wb", 32'h1234_5678, wb_seen);
      apb(1'h1, nor_pkg::NOR_OFF_EVCLR, 32'h1);
      @(posedge mclk);
      selfid_rx <= 1'h1;
      dma_abort <= 1'h1;
      #1 chk("host_irq", 0, host_irq);
      @(posedge mclk);
      selfid_rx <= 1'h0;
      dma_abort <= 1'h0;
      rdc(nor_pkg::NOR_OFF_EVENT, 32'h6);
      chk("masked irq", 0, host_irq);
      apb(1'h1, nor_pkg::NOR_OFF_EVCLR, 32'hff);
      apb(1'h1, nor_pkg::NOR_OFF_CTRL, 32'h3);
      slow <= 1'h1;
      req(48'h0000_0000_0006, 1, 5, 1, 1, 4'h1);
      rxq(32'h4433_2211);
      rxq(32'h8877_6655);
      repeat (10) @(posedge mclk);
      chk("hm count", 2, far.mem_log.size());
      chk("hm addr0", 32'h4, far.mem_log[0].addr);
      chk("hm be0", 4'hc, far.mem_log[0].be);
      chk("hm data0", 16'h2211, far.mem_log[0].data[31:16]);
      chk("hm addr1", 32'h8, far.mem_log[1].addr);
      chk("hm be1", 4'h7, far.mem_log[1].be);
      chk("hm data1", 24'h55_4433, far.mem_log[1].data[23:0]);
      req(48'h0000_0000_0002, 1, 4, 1, 1, 4'h1);
      rxq(32'hddcc_bbaa);
      repeat (10) @(posedge mclk);
      chk("hm be2", 4'hc, far.mem_log[2].be);
      chk("hm flush be", 4'h3, far.mem_log[3].be);
      chk("hm flush", 32'h0000_ddcc, far.mem_log[3].data);
      rdc(nor_pkg::NOR_OFF_EVENT, 32'h8);
      apb(1'h1, nor_pkg::NOR_OFF_CTRL, 32'h1);
      req(48'h0000_0000_0010, 1, 0, 1, 1, 4'h2);
      req(48'h0000_0000_1000, 0, 4, 1, 1, 4'h2);
      repeat (6) @(posedge mclk);
      chk("phys read", 32'h1000, rd_seen);
      chk("len zero", 4, far.mem_log.size());
      apb(1'h1, nor_pkg::NOR_OFF_TOP_LO, 32'hff);
      apb(1'h1, nor_pkg::NOR_OFF_TOP_HI, 32'h0);
      apb(1'h1, nor_pkg::NOR_OFF_CTRL, 32'h5);
      req(48'h0000_0000_0100, 0, 4, 1, 1, 4'h2);
      repeat (4) @(posedge mclk);
      chk("top moved", 6, sw_log.size());
      @(posedge mclk);
      tx_in_valid <= 1'h1;
      tx_in <= '{32'haabb_ccdd, 3'h3};
      do @(posedge mclk); while (tx_in_ready !== 1'h1);
      tx_in_valid <= 1'h0;
      repeat (6) @(posedge mclk);
      chk("tx pad", 32'h00bb_ccdd, far.tx_log[0]);
      complete_run();
   end
endmodule
`default_nettype wire
